/* File: smr_pkg.sv */
// shared constants and types for the sensor command, mode, reset and heater block
package smr_pkg;
	// command codes
	localparam logic [15:0] CMD_ACCEL     = 16'h2B32; // accelerated periodic acquisition
	localparam logic [15:0] CMD_BREAK     = 16'h3093;
	localparam logic [15:0] CMD_SOFT_RST  = 16'h30A2;
	localparam logic [15:0] CMD_HEAT_ON   = 16'h306D;
	localparam logic [15:0] CMD_HEAT_OFF  = 16'h3066;
	localparam logic [15:0] CMD_FETCH     = 16'hE000;
	localparam logic [15:0] CMD_STAT_RD   = 16'hF32D;
	localparam logic [15:0] CMD_STAT_CLR  = 16'h3041;
	localparam logic [7:0]  GC_RESET_BYTE = 8'h06;

	// status register bit positions
	localparam int ST_ALERT = 15;
	localparam int ST_HEAT  = 13;
	localparam int ST_RHTA  = 11;
	localparam int ST_TTA   = 10;
	localparam int ST_RST   = 4;
	localparam int ST_CMD   = 1;
	localparam int ST_WCRC  = 0;
	localparam logic [15:0] STATUS_RESET = 16'h8010;

	// timing
	localparam longint CLK_HZ       = 125000000;
	localparam longint ACCEL_RATE_HZ = 4;
	localparam int     BREAK_MAX_MS  = 15;
	localparam int     RST_PIN_MIN_NS = 1000;
	localparam int     CLK_NS         = 8;
	localparam int     ACCEL_PERIOD_CYC = int'(CLK_HZ / ACCEL_RATE_HZ);
	localparam int     BREAK_MAX_CYC    = int'(CLK_HZ / 1000 * BREAK_MAX_MS);
	localparam int     RST_PIN_MIN_CYC  = (RST_PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int     RELOAD_CYC       = 16;
	localparam int     RST_BUSY_CYC     = 32;

	typedef enum logic [1:0] {
		SMR_IDLE   = 2'b00,
		SMR_PERIOD = 2'b01,
		SMR_STOP   = 2'b10
	} smr_mode_e;
endpackage : smr_pkg

/* File: smr_cmd_if.sv */
// command carrier between decoder and controller
`timescale 1ns/10ps
interface smr_cmd_if;
	logic        valid;
	logic [15:0] code;
	logic        gc_reset;
	logic        accept;
	modport src (output valid, output code, output gc_reset, input accept);
	modport dst (input valid, input code, input gc_reset, output accept);
endinterface : smr_cmd_if

/* File: smr_rst_gen.sv */
// reset source combiner: pin filter and busy window
`timescale 1ns/10ps
module smr_rst_gen (
	input  wire logic clock_i,
	input  wire logic srst_i,
	input  wire logic external_reset_low_input_i,
	input  wire logic soft_req_i,
	input  wire logic gc_req_i,
	output logic      full_rst_o,
	output logic      soft_rst_o,
	output logic      busy_o
);
	logic [7:0] low_cnt;
	logic [7:0] busy_cnt;
	logic       pin_fire;

	// count pin low cycles, fire once at minimum width
	always_ff @(posedge clock_i) begin
		if (srst_i || external_reset_low_input_i) begin
			low_cnt <= 8'h00;
		end else if (low_cnt != 8'hFF) begin
			low_cnt <= low_cnt + 8'h01;
		end
	end
	assign pin_fire = (low_cnt == 8'(smr_pkg::RST_PIN_MIN_CYC - 1)) && !external_reset_low_input_i;

	// full reset from power, pin or general call; soft separately
	always_ff @(posedge clock_i) begin
		full_rst_o <= srst_i || pin_fire || gc_req_i;
		soft_rst_o <= !srst_i && soft_req_i;
	end

	// busy window while any reset procedure runs
	always_ff @(posedge clock_i) begin
		if (srst_i || pin_fire || gc_req_i || soft_req_i || !external_reset_low_input_i) begin
			busy_cnt <= 8'(smr_pkg::RST_BUSY_CYC);
		end else if (busy_cnt != 8'h00) begin
			busy_cnt <= busy_cnt - 8'h01;
		end
	end
	assign busy_o = (busy_cnt != 8'h00);
endmodule : smr_rst_gen

/* File: smr_ctrl.sv */
// command interpreter: accelerated periodic mode, break, resets and heater control
`timescale 1ns/10ps
module smr_ctrl (
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	input  wire logic        external_reset_low_input_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [15:0] cmd_code_i,
	input  wire logic        cmd_crc_err_i,
	input  wire logic        gc_valid_i,
	input  wire logic [7:0]  gc_byte_i,
	input  wire logic        wr_crc_err_i,
	input  wire logic        link_reset_i,
	input  wire logic        rh_alert_i,
	input  wire logic        t_alert_i,
	input  wire logic        meas_done_i,
	output logic             cmd_ready_o,
	output logic             link_reset_o,
	output logic             meas_start_o,
	output logic             cal_reload_o,
	output logic             heater_on_o,
	output logic             accelerated_response_mode_o,
	output logic             periodic_o,
	output logic [15:0]      status_o,
	output logic             busy_o
);
	smr_cmd_if cmd ();

	logic                 full_rst;
	logic                 soft_rst;
	logic                 rst_busy;
	logic                 any_rst;
	smr_pkg::smr_mode_e   mode;
	logic [31:0]          tick_cnt;
	logic                 tick;
	logic                 meas_busy;
	logic [4:0]           reload_cnt;
	logic                 take;
	logic                 soft_req;
	logic                 gc_req;
	logic                 known;
	logic                 start_req;
	logic                 cmd_crc_q;
	logic                 wr_crc_q;
	logic                 exec;
	logic                 st_alert;
	logic                 st_rh_alert;
	logic                 st_t_alert;
	logic                 st_reset;
	logic                 st_cmd_err;
	logic                 st_wr_err;

	// command decoder feeding the controller
	smr_cmd_dec u_dec (
		.clock_i     (clock_i),
		.srst_i      (srst_i),
		.cmd_valid_i (cmd_valid_i),
		.cmd_code_i  (cmd_code_i),
		.gc_valid_i  (gc_valid_i),
		.gc_byte_i   (gc_byte_i),
		.cmd         (cmd)
	);

	// reset sources
	smr_rst_gen u_rst (
		.clock_i                    (clock_i),
		.srst_i                     (srst_i),
		.external_reset_low_input_i (external_reset_low_input_i),
		.soft_req_i                 (soft_req),
		.gc_req_i                   (gc_req),
		.full_rst_o                 (full_rst),
		.soft_rst_o                 (soft_rst),
		.busy_o                     (rst_busy)
	);

	assign any_rst = full_rst || soft_rst;

	assign cmd.accept  = !rst_busy && !any_rst;
	assign cmd_ready_o = cmd.accept;
	assign busy_o      = rst_busy;
	assign take        = cmd.valid && cmd.accept;

	// checksum flags registered so they line up with the registered command
	always_ff @(posedge clock_i) begin
		cmd_crc_q <= !srst_i && cmd_crc_err_i;
		wr_crc_q  <= !srst_i && wr_crc_err_i;
	end

	// a command that fails its checksum is not processed
	assign exec = take && !cmd.gc_reset && !cmd_crc_q;

	assign soft_req = exec && (cmd.code == smr_pkg::CMD_SOFT_RST);
	// general call reset acts as pin reset
	assign gc_req   = take && cmd.gc_reset;

	// recognised command set
	assign known = (cmd.code == smr_pkg::CMD_ACCEL) || (cmd.code == smr_pkg::CMD_BREAK)
		|| (cmd.code == smr_pkg::CMD_SOFT_RST) || (cmd.code == smr_pkg::CMD_HEAT_ON)
		|| (cmd.code == smr_pkg::CMD_HEAT_OFF) || (cmd.code == smr_pkg::CMD_FETCH)
		|| (cmd.code == smr_pkg::CMD_STAT_RD) || (cmd.code == smr_pkg::CMD_STAT_CLR);

	// interface reset passed on; status untouched by it
	always_ff @(posedge clock_i) begin
		link_reset_o <= !srst_i && link_reset_i;
	end

	// mode state machine
	always_ff @(posedge clock_i) begin
		if (any_rst) begin
			mode <= smr_pkg::SMR_IDLE;
			accelerated_response_mode_o <= 1'b0;
		end else begin
			case (mode)
				smr_pkg::SMR_IDLE: begin
					if (exec && cmd.code == smr_pkg::CMD_ACCEL) begin
						mode <= smr_pkg::SMR_PERIOD;
						accelerated_response_mode_o <= 1'b1;
					end
				end
				smr_pkg::SMR_PERIOD: begin
					// break stops like any periodic mode
					if (exec && cmd.code == smr_pkg::CMD_BREAK) begin
						mode <= smr_pkg::SMR_STOP;
					end
				end
				smr_pkg::SMR_STOP: begin
					if (!meas_busy || meas_done_i) begin
						mode <= smr_pkg::SMR_IDLE;
						accelerated_response_mode_o <= 1'b0;
					end
				end
				default: mode <= smr_pkg::SMR_IDLE;
			endcase
		end
	end
	assign periodic_o = (mode == smr_pkg::SMR_PERIOD);

	// sample tick at four per second
	always_ff @(posedge clock_i) begin
		if (any_rst || mode != smr_pkg::SMR_PERIOD) begin
			tick_cnt <= 32'h0000_0000;
		end else if (tick_cnt == 32'(smr_pkg::ACCEL_PERIOD_CYC - 1)) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end
	assign tick = (mode == smr_pkg::SMR_PERIOD) && (tick_cnt == 32'h0000_0000);

	always_ff @(posedge clock_i) begin
		if (any_rst) begin
			reload_cnt <= 5'(smr_pkg::RELOAD_CYC); // reload after reset
		end else if (tick && reload_cnt == 5'h00) begin
			reload_cnt <= 5'(smr_pkg::RELOAD_CYC);
		end else if (reload_cnt != 5'h00) begin
			reload_cnt <= reload_cnt - 5'h01;
		end
	end
	assign cal_reload_o = (reload_cnt != 5'h00);
	assign start_req    = (reload_cnt == 5'h01) && (mode == smr_pkg::SMR_PERIOD);

	// measurement start pulse and busy tracking
	always_ff @(posedge clock_i) begin
		if (any_rst) begin
			meas_start_o <= 1'b0;
			meas_busy    <= 1'b0;
		end else begin
			meas_start_o <= start_req && !meas_busy;
			if (start_req && !meas_busy) begin
				meas_busy <= 1'b1;
			end else if (meas_done_i) begin
				meas_busy <= 1'b0;
			end
		end
	end

	// heater by command only, off after any full or soft reset; the link reset leaves it
	always_ff @(posedge clock_i) begin
		if (any_rst) begin
			heater_on_o <= 1'b0;
		end else if (exec && cmd.code == smr_pkg::CMD_HEAT_ON) begin
			heater_on_o <= 1'b1;
		end else if (exec && cmd.code == smr_pkg::CMD_HEAT_OFF) begin
			heater_on_o <= 1'b0;
		end
	end

	// reset flag, set wins over clear
	always_ff @(posedge clock_i) begin
		if (any_rst) begin
			st_reset <= 1'b1;
		end else if (exec && cmd.code == smr_pkg::CMD_STAT_CLR) begin
			st_reset <= 1'b0;
		end
	end

	// alert flags, sticky, set wins over clear
	always_ff @(posedge clock_i) begin
		if (any_rst) begin
			st_rh_alert <= 1'b0;
			st_t_alert  <= 1'b0;
		end else begin
			if (rh_alert_i) begin
				st_rh_alert <= 1'b1;
			end else if (exec && cmd.code == smr_pkg::CMD_STAT_CLR) begin
				st_rh_alert <= 1'b0;
			end
			if (t_alert_i) begin
				st_t_alert <= 1'b1;
			end else if (exec && cmd.code == smr_pkg::CMD_STAT_CLR) begin
				st_t_alert <= 1'b0;
			end
		end
	end

	// alert summary, set by alerts or reset
	always_ff @(posedge clock_i) begin
		if (any_rst || rh_alert_i || t_alert_i) begin
			st_alert <= 1'b1;
		end else if (exec && cmd.code == smr_pkg::CMD_STAT_CLR) begin
			st_alert <= 1'b0;
		end
	end

	// last command and write checksum results
	always_ff @(posedge clock_i) begin
		if (any_rst) begin
			st_cmd_err <= 1'b0;
			st_wr_err  <= 1'b0;
		end else if (take && !cmd.gc_reset) begin
			st_cmd_err <= cmd_crc_q || !known;
			st_wr_err  <= wr_crc_q;
		end
	end

	// status word from the flags; heater mirrored, reserved bits zero
	always_comb begin
		status_o                    = 16'h0000;
		status_o[smr_pkg::ST_ALERT] = st_alert;
		status_o[smr_pkg::ST_HEAT]  = heater_on_o;
		status_o[smr_pkg::ST_RHTA]  = st_rh_alert;
		status_o[smr_pkg::ST_TTA]   = st_t_alert;
		status_o[smr_pkg::ST_RST]   = st_reset;
		status_o[smr_pkg::ST_CMD]   = st_cmd_err;
		status_o[smr_pkg::ST_WCRC]  = st_wr_err;
	end

	// a command refused during reset leaves the heater alone
	a_cmd_blocked: assert property (@(posedge clock_i) disable iff (srst_i)
		cmd.valid && rst_busy && !any_rst |=> $stable(heater_on_o))
		else $error("command acted on during reset");

	sequence s_break_taken;
		exec && cmd.code == smr_pkg::CMD_BREAK && mode == smr_pkg::SMR_PERIOD;
	endsequence
	// break leads to stop state next
	a_break_stop: assert property (@(posedge clock_i) disable iff (srst_i)
		s_break_taken |=> mode == smr_pkg::SMR_STOP) else $error("break ignored");

	sequence s_stop_waiting;
		mode == smr_pkg::SMR_STOP && meas_busy && !meas_done_i && !any_rst;
	endsequence
	// single-shot only once the running measurement ends
	a_break_wait: assert property (@(posedge clock_i) disable iff (srst_i)
		s_stop_waiting |=> mode == smr_pkg::SMR_STOP) else $error("break cut measurement");

	a_heat_reset: assert property (@(posedge clock_i)
		any_rst |=> !heater_on_o) else $error("heater on after reset");

	a_idle_reset: assert property (@(posedge clock_i)
		any_rst |=> mode == smr_pkg::SMR_IDLE && !periodic_o) else $error("not idle");

	a_rst_flag: assert property (@(posedge clock_i)
		any_rst |=> status_o[smr_pkg::ST_RST]) else $error("reset flag clear");

	sequence s_accel_taken;
		exec && cmd.code == smr_pkg::CMD_ACCEL && mode == smr_pkg::SMR_IDLE;
	endsequence
	a_accel_go: assert property (@(posedge clock_i) disable iff (srst_i)
		s_accel_taken |=> periodic_o && accelerated_response_mode_o) else $error("no start");

	// general call gives full reset one cycle on
	a_gc_reset: assert property (@(posedge clock_i) disable iff (srst_i)
		gc_req |=> full_rst) else $error("general call reset lost");

	// an RH alert event sets its sticky flag and the summary
	a_alert_flag: assert property (@(posedge clock_i) disable iff (srst_i)
		rh_alert_i && !any_rst |=> status_o[smr_pkg::ST_RHTA] && status_o[smr_pkg::ST_ALERT])
		else $error("alert flag lost");

	a_heat_cmd: assert property (@(posedge clock_i) disable iff (srst_i)
		exec && cmd.code == smr_pkg::CMD_HEAT_ON |=> heater_on_o) else $error("heater not on");

	a_reload_pre: assert property (@(posedge clock_i) disable iff (srst_i)
		meas_start_o |-> $past(cal_reload_o)) else $error("start without reload");
endmodule : smr_ctrl

/* File: smr_cmd_dec.sv */
// command decoder: registers link commands and general-call bytes
`timescale 1ns/10ps
module smr_cmd_dec (
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [15:0] cmd_code_i,
	input  wire logic        gc_valid_i,
	input  wire logic [7:0]  gc_byte_i,
	smr_cmd_if.src           cmd
);
	// register one command per cycle; only the reset byte counts on general call
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			cmd.valid    <= 1'b0;
			cmd.code     <= 16'h0000;
			cmd.gc_reset <= 1'b0;
		end else begin
			cmd.valid    <= cmd_valid_i || (gc_valid_i && gc_byte_i == smr_pkg::GC_RESET_BYTE);
			cmd.code     <= cmd_code_i;
			cmd.gc_reset <= gc_valid_i && gc_byte_i == smr_pkg::GC_RESET_BYTE;
		end
	end
endmodule : smr_cmd_dec

/* File: smr_host_model.sv */
// host side model: issues commands, general calls, link recovery and pin resets
`timescale 1ns/10ps
module smr_host_model (
	input  wire logic        clock_i,
	input  wire logic        busy_i,
	output logic             external_reset_low_pin_o,
	output logic             cmd_valid_o,
	output logic [15:0]      cmd_code_o,
	output logic             cmd_crc_err_o,
	output logic             gc_valid_o,
	output logic [7:0]       gc_byte_o,
	output logic             wr_crc_err_o,
	output logic             link_reset_o
);
	// idle levels at time zero; the pin rests high through its pull-up
	initial begin
		external_reset_low_pin_o = 1'h1;
		cmd_valid_o = 1'h0;
		cmd_code_o = 16'h0000;
		cmd_crc_err_o = 1'h0;
		gc_valid_o = 1'h0;
		gc_byte_o = 8'h00;
		wr_crc_err_o = 1'h0;
		link_reset_o = 1'h0;
	end

	// one command for one cycle, then the code lines show junk
	task send_cmd(input logic [15:0] code, input logic crc_bad);
		if (code == smr_pkg::CMD_SOFT_RST) while (busy_i !== 1'h0) @(negedge clock_i);
		@(negedge clock_i);
		cmd_valid_o = 1'h1;
		cmd_code_o = code;
		cmd_crc_err_o = crc_bad;
		@(negedge clock_i);
		cmd_valid_o = 1'h0;
		cmd_crc_err_o = 1'h0;
		cmd_code_o = ~cmd_code_o;
	endtask : send_cmd

	// write checksum flag that travels with the next command
	task set_wr_crc(input logic bad);
		@(negedge clock_i);
		wr_crc_err_o = bad;
	endtask : set_wr_crc

	// second byte of a general call
	task send_gc(input logic [7:0] value);
		@(negedge clock_i);
		gc_valid_o = 1'h1;
		gc_byte_o = value;
		@(negedge clock_i);
		gc_valid_o = 1'h0;
		gc_byte_o = ~gc_byte_o;
	endtask : send_gc

	// clock toggles with data high, seen as one detect pulse
	task link_recover;
		@(negedge clock_i);
		link_reset_o = 1'h1;
		@(negedge clock_i);
		link_reset_o = 1'h0;
	endtask : link_recover

	// pin low for at least the minimum time
	task pin_reset(input int cycles);
		@(negedge clock_i);
		external_reset_low_pin_o = 1'h0;
		repeat (cycles) @(negedge clock_i);
		external_reset_low_pin_o = 1'h1;
	endtask : pin_reset
endmodule : smr_host_model

/* File: testbench.sv */
// self-checking bench for the command, mode, reset and heater controller
`timescale 1ns/10ps
`define CHK(got, exp) \
	begin n_checks++; if ((got) !== (exp)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
	logic        clock_i;
	logic        srst_i;
	logic        pin_n;
	logic        cmd_valid;
	logic [15:0] cmd_code;
	logic        cmd_crc_err;
	logic        gc_valid;
	logic [7:0]  gc_byte;
	logic        wr_crc_err;
	logic        link_rst_in;
	logic        rh_alert_i;
	logic        t_alert_i;
	logic        meas_done_i;
	logic        cmd_ready_o;
	logic        link_reset_o;
	logic        meas_start_o;
	logic        cal_reload_o;
	logic        heater_on_o;
	logic        accel_o;
	logic        periodic_o;
	logic [15:0] status_o;
	logic        busy_o;
	logic        reload_seen;
	int          err_count = 0;
	int          n_checks = 0;

	smr_ctrl smr_ctrl_i (.clock_i(clock_i), .srst_i(srst_i),
		.external_reset_low_input_i(pin_n), .cmd_valid_i(cmd_valid),
		.cmd_code_i(cmd_code), .cmd_crc_err_i(cmd_crc_err), .gc_valid_i(gc_valid),
		.gc_byte_i(gc_byte), .wr_crc_err_i(wr_crc_err), .link_reset_i(link_rst_in),
		.rh_alert_i(rh_alert_i), .t_alert_i(t_alert_i), .meas_done_i(meas_done_i),
		.cmd_ready_o(cmd_ready_o), .link_reset_o(link_reset_o),
		.meas_start_o(meas_start_o), .cal_reload_o(cal_reload_o),
		.heater_on_o(heater_on_o), .accelerated_response_mode_o(accel_o),
		.periodic_o(periodic_o), .status_o(status_o), .busy_o(busy_o));

	smr_host_model smr_host_model_i (.clock_i(clock_i), .busy_i(busy_o),
		.external_reset_low_pin_o(pin_n), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
		.cmd_crc_err_o(cmd_crc_err), .gc_valid_o(gc_valid), .gc_byte_o(gc_byte),
		.wr_crc_err_o(wr_crc_err), .link_reset_o(link_rst_in));

	// 125 MHz clock
	initial begin
		clock_i = 1'h0;
		forever #4 clock_i = ~clock_i;
	end

	// remembers any calibration reload
	always @(posedge clock_i) if (cal_reload_o === 1'h1) reload_seen <= 1'h1;

	task finish_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task settle;
		repeat (3) @(negedge clock_i);
	endtask : settle

	// bounded wait until the reset procedure is over
	task wait_idle;
		for (int i = 0; i < 400 && busy_o !== 1'h0; i++) @(negedge clock_i);
		`CHK(busy_o, 1'h0)
	endtask : wait_idle

	task cmd(input logic [15:0] code);
		smr_host_model_i.send_cmd(code, 1'h0);
		settle();
	endtask : cmd

	task t_reset_state;
		wait_idle();
		`CHK(heater_on_o, 1'h0)
		`CHK(periodic_o, 1'h0)
		`CHK(status_o, smr_pkg::STATUS_RESET)
	endtask : t_reset_state

	task t_heater_status;
		cmd(smr_pkg::CMD_HEAT_ON);
		`CHK(heater_on_o, 1'h1)
		`CHK(status_o[smr_pkg::ST_HEAT], 1'h1)
		cmd(smr_pkg::CMD_HEAT_OFF);
		`CHK(heater_on_o, 1'h0)
		smr_host_model_i.send_cmd(smr_pkg::CMD_HEAT_ON, 1'h1);
		settle();
		`CHK(heater_on_o, 1'h0)
		`CHK(status_o[smr_pkg::ST_CMD], 1'h1)
		cmd(smr_pkg::CMD_STAT_CLR);
		`CHK(status_o, 16'h0000)
		smr_host_model_i.set_wr_crc(1'h1);
		cmd(16'h1234);
		smr_host_model_i.set_wr_crc(1'h0);
		`CHK(status_o[smr_pkg::ST_CMD], 1'h1)
		`CHK(status_o[smr_pkg::ST_WCRC], 1'h1)
		cmd(smr_pkg::CMD_STAT_RD);
		`CHK(status_o[smr_pkg::ST_CMD], 1'h0)
		`CHK(status_o[smr_pkg::ST_WCRC], 1'h0)
		@(negedge clock_i) rh_alert_i = 1'h1;
		@(negedge clock_i) rh_alert_i = 1'h0;
		settle();
		`CHK(status_o[smr_pkg::ST_RHTA], 1'h1)
		`CHK(status_o[smr_pkg::ST_TTA], 1'h0)
		`CHK(status_o[smr_pkg::ST_ALERT], 1'h1)
		@(negedge clock_i) t_alert_i = 1'h1;
		@(negedge clock_i) t_alert_i = 1'h0;
		settle();
		`CHK(status_o[smr_pkg::ST_TTA], 1'h1)
	endtask : t_heater_status

	task t_accel_break;
		reload_seen = 1'h0;
		cmd(smr_pkg::CMD_ACCEL);
		`CHK(periodic_o, 1'h1)
		`CHK(accel_o, 1'h1)
		cmd(smr_pkg::CMD_FETCH);
		`CHK(periodic_o, 1'h1)
		for (int i = 0; i < 40 && meas_start_o !== 1'h1; i++) @(negedge clock_i);
		`CHK(meas_start_o, 1'h1)
		`CHK(reload_seen, 1'h1)
		cmd(smr_pkg::CMD_BREAK);
		`CHK(periodic_o, 1'h0)
		`CHK(accel_o, 1'h1)
		@(negedge clock_i) meas_done_i = 1'h1;
		@(negedge clock_i) meas_done_i = 1'h0;
		for (int i = 0; i < 50 && accel_o !== 1'h0; i++) @(negedge clock_i);
		`CHK(periodic_o, 1'h0)
		`CHK(accel_o, 1'h0)
	endtask : t_accel_break

	task t_link_reset;
		cmd(smr_pkg::CMD_HEAT_ON);
		smr_host_model_i.link_recover();
		for (int i = 0; i < 10 && link_reset_o !== 1'h1; i++) @(negedge clock_i);
		`CHK(link_reset_o, 1'h1)
		settle();
		`CHK(heater_on_o, 1'h1)
		`CHK(status_o[smr_pkg::ST_HEAT], 1'h1)
	endtask : t_link_reset

	task t_soft_reset;
		reload_seen = 1'h0;
		smr_host_model_i.send_cmd(smr_pkg::CMD_SOFT_RST, 1'h0);
		for (int i = 0; i < 20 && busy_o !== 1'h1; i++) @(negedge clock_i);
		`CHK(busy_o, 1'h1)
		`CHK(cmd_ready_o, 1'h0)
		smr_host_model_i.send_cmd(smr_pkg::CMD_HEAT_ON, 1'h0);
		wait_idle();
		settle();
		`CHK(cmd_ready_o, 1'h1)
		`CHK(heater_on_o, 1'h0)
		`CHK(status_o[smr_pkg::ST_RST], 1'h1)
		`CHK(reload_seen, 1'h1)
	endtask : t_soft_reset

	task t_general_call;
		cmd(smr_pkg::CMD_HEAT_ON);
		smr_host_model_i.send_gc(8'h04);
		settle();
		`CHK(heater_on_o, 1'h1)
		smr_host_model_i.send_gc(smr_pkg::GC_RESET_BYTE);
		settle();
		wait_idle();
		`CHK(heater_on_o, 1'h0)
		`CHK(periodic_o, 1'h0)
	endtask : t_general_call

	task t_pin_reset;
		cmd(smr_pkg::CMD_STAT_CLR);
		cmd(smr_pkg::CMD_HEAT_ON);
		cmd(smr_pkg::CMD_ACCEL);
		smr_host_model_i.pin_reset(smr_pkg::RST_PIN_MIN_CYC + 5);
		wait_idle();
		`CHK(heater_on_o, 1'h0)
		`CHK(accel_o, 1'h0)
		`CHK(periodic_o, 1'h0)
		`CHK(status_o[smr_pkg::ST_RST], 1'h1)
	endtask : t_pin_reset

	// reset for five cycles, then each scenario in turn
	initial begin
		srst_i = 1'h1;
		rh_alert_i = 1'h0;
		t_alert_i = 1'h0;
		meas_done_i = 1'h0;
		reload_seen = 1'h0;
		repeat (5) @(negedge clock_i);
		srst_i = 1'h0;
		t_reset_state();
		t_heater_status();
		t_accel_break();
		t_link_reset();
		t_soft_reset();
		t_general_call();
		t_pin_reset();
		finish_test();
	end

	// watchdog well beyond the few hundred cycles the scenarios need
	initial begin
		#(8 * 20000);
		err_count++;
		finish_test();
	end
endmodule : testbench
